/* verilog/spfs_pkg.sv */
/*
 Constants shared by the self-programming flash sequencer: register map,
 control field positions, command patterns, pointer values and timing.
 Assumes a 40 MHz CPU clock and a 32-word page of 16-bit words.
*/
package spfs_pkg;

   // Page geometry
   localparam int unsigned PAGE_WORDS = 32;
   localparam int unsigned WIDX_W = 5;
   localparam int unsigned PAGE_W = 7;
   localparam logic [6:0] RWW_PAGES = 7'h60;
   localparam int unsigned Z_WORD_LSB = 1;
   localparam int unsigned Z_PAGE_LSB = 6;

   // Register byte offsets
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_ZPTR = 12'h004;
   localparam logic [11:0] ADDR_DATA = 12'h008;
   localparam logic [11:0] ADDR_INSTR = 12'h00C;
   localparam logic [11:0] ADDR_RESULT = 12'h010;
   localparam logic [11:0] ADDR_STATUS = 12'h014;

   // Control register fields
   localparam int unsigned CTRL_IE = 7;
   localparam int unsigned CTRL_BUSY = 6;

   // Instruction register fields
   localparam int unsigned INSTR_STORE = 0;
   localparam int unsigned INSTR_LOAD = 1;

   // Command patterns in the low five control bits
   localparam logic [4:0] PAT_REEN = 5'h11;
   localparam logic [4:0] PAT_LOCK = 5'h09;
   localparam logic [4:0] PAT_WRITE = 5'h05;
   localparam logic [4:0] PAT_LOAD = 5'h01;

   // Pointer values for fuse and lock reads
   localparam logic [15:0] Z_FUSE_LOW = 16'h0000;
   localparam logic [15:0] Z_LOCK = 16'h0001;
   localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
   localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;

   // Arming windows in cycles after the control write
   localparam logic [2:0] STORE_WINDOW = 3'h4;
   localparam logic [2:0] LOAD_WINDOW = 3'h3;

   // Reset and fill values
   localparam logic [7:0] LOCK_RESET = 8'hFF;
   localparam logic [15:0] BUF_ERASED = 16'hFFFF;
   localparam logic [3:0] EXT_PAD = 4'hF;
   localparam logic [1:0] LOCK_PAD = 2'h3;
   localparam logic [7:0] PLAIN_LOAD = 8'hFF;

   // Programming time
   localparam int unsigned PROG_TIME_US = 3700;
   localparam int unsigned CLK_MHZ = 40;
   localparam int unsigned PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

   function automatic logic spfs_pattern_ok(input logic [4:0] p);
      spfs_pattern_ok = (p == PAT_REEN) || (p == PAT_LOCK) || (p == PAT_WRITE) || (p == PAT_LOAD);
   endfunction : spfs_pattern_ok

endpackage : spfs_pkg

/* verilog/spfs_buf_if.sv */
/*
 Interface between the sequencer and its temporary page buffer.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface spfs_buf_if;
   logic clear;
   logic we;
   logic [4:0] widx;
   logic [15:0] wdata;
   logic [4:0] ridx;
   logic [15:0] rdata;

   modport ctl (output clear, output we, output widx, output wdata, output ridx, input rdata);
   modport mem (input clear, input we, input widx, input wdata, input ridx, output rdata);
endinterface : spfs_buf_if

/* verilog/spfs_page_buf.sv */
/*
 Temporary page buffer: one page of 16-bit words in flip-flops.
 Assumes the controller raises clear for one cycle to erase the whole page.
*/
`timescale 1ns/1ps
module spfs_page_buf
   import spfs_pkg::*;
#(
   parameter int unsigned WORDS = PAGE_WORDS
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Controller side
   spfs_buf_if.mem bus
);

   generate
      if (WORDS != (1 << WIDX_W)) begin : g_chk
         $error("spfs_page_buf: WORDS must match the word index width");
      end
   endgenerate

   logic [15:0] mem_q [WORDS];
   logic [15:0] rdata_q;

   assign bus.rdata = rdata_q;

   // Erased on reset and on clear; clear wins over a write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < WORDS; i++) begin
            mem_q[i] <= BUF_ERASED;
         end
      end else if (bus.clear) begin
         for (int i = 0; i < WORDS; i++) begin
            mem_q[i] <= BUF_ERASED;
         end
      end else if (bus.we) begin
         mem_q[bus.widx] <= bus.wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= BUF_ERASED;
      end else begin
         rdata_q <= mem_q[bus.ridx];
      end
   end

endmodule : spfs_page_buf

/* verilog/spfs_top.sv */
/*
 Self-programming flash sequencer: control register, pointer and data
 registers, store and load instruction triggers over APB, temporary page
 buffer, page-write timer, lock bits and fuse/lock readback.
 Assumes an external flash macro that takes a start pulse and page number
 and reads the buffer through the index port, an EEPROM write-busy level
 from another domain, and a power-on reset separate from the system reset.
*/
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module spfs_top
   import spfs_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES = PROG_CYCLES,
   parameter logic [7:0] FUSE_LOW = 8'h62,
   parameter logic [7:0] FUSE_HIGH = 8'hDF,
   parameter logic [3:0] FUSE_EXT = 4'h9
) (
   // Clock and resets
   input wire logic pclk,
   input wire logic presetn,
   input wire logic por_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // EEPROM status
   input wire logic eeprom_write_busy,
   // Flash macro
   output logic flash_wr_start,
   output logic [6:0] flash_wr_page,
   input wire logic [4:0] flash_buf_idx,
   output logic [15:0] flash_buf_data,
   // CPU side
   output logic cpu_halt,
   output logic rww_read_block,
   output logic selfprog_irq
);

   localparam int unsigned CNT_W = $clog2(WRITE_CYCLES + 1);

   generate
      if (WRITE_CYCLES < 2) begin : g_chk
         $error("spfs_top: WRITE_CYCLES must be at least 2");
      end
   endgenerate

   typedef enum logic [1:0] {
      SPFS_IDLE = 2'b01,
      SPFS_PROG = 2'b10
   } spfs_state_t;

   spfs_buf_if buf_bus ();

   // Register state
   logic ie_q;
   logic [15:0] zptr_q;
   logic [15:0] data_q;
   logic [7:0] result_q;
   logic [7:0] lock_q;
   logic rww_busy_q;
   logic loading_q;
   logic special_q;

   // Arming state
   logic armed_q;
   logic [4:0] cmd_q;
   logic [2:0] win_q;

   // Write engine, kept on the power-on reset
   spfs_state_t state_q;
   logic [CNT_W-1:0] cnt_q;
   logic [6:0] page_q;
   logic no_read_while_write_section_q;
   logic start_q;

   // EEPROM busy synchroniser
   logic ee_meta_q;
   logic ee_sync_q;
   logic ee_prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ee_meta_q <= 1'b0;
         ee_sync_q <= 1'b0;
         ee_prev_q <= 1'b0;
      end else begin
         ee_meta_q <= eeprom_write_busy;
         ee_sync_q <= ee_meta_q;
         ee_prev_q <= ee_sync_q;
      end
   end

   wire ee_busy = ee_sync_q;
   wire ee_start = ee_sync_q && !ee_prev_q;

   // APB decode
   wire apb_acc = psel && penable;
   wire apb_wr = apb_acc && pwrite;
   wire hit_ctrl = (paddr == ADDR_CTRL);
   wire hit_zptr = (paddr == ADDR_ZPTR);
   wire hit_data = (paddr == ADDR_DATA);
   wire hit_instr = (paddr == ADDR_INSTR);
   wire hit_result = (paddr == ADDR_RESULT);
   wire hit_status = (paddr == ADDR_STATUS);
   wire hit_any = hit_ctrl || hit_zptr || hit_data || hit_instr || hit_result || hit_status;

   assign pready = 1'b1;
   assign pslverr = apb_acc && !hit_any;

   wire busy = (state_q == SPFS_PROG);
   wire selfprog_en = armed_q || busy;

   wire [4:0] wr_pat = pwdata[4:0];
   wire ctrl_wr = apb_wr && hit_ctrl;
   wire arm_ok = ctrl_wr && spfs_pattern_ok(wr_pat) && !busy && !ee_busy;

   wire store_req = apb_wr && hit_instr && pwdata[INSTR_STORE];
   wire load_req = apb_wr && hit_instr && pwdata[INSTR_LOAD];

   // Store taken only inside its window, never while EEPROM writes
   wire store_go = store_req && armed_q && (win_q <= STORE_WINDOW) && !ee_busy;
   wire go_load = store_go && (cmd_q == PAT_LOAD);
   wire go_write = store_go && (cmd_q == PAT_WRITE);
   wire go_lock = store_go && (cmd_q == PAT_LOCK);
   wire go_reen = store_go && (cmd_q == PAT_REEN);

   // Special read window for lock and fuse bytes
   wire special_go = load_req && armed_q && (cmd_q == PAT_LOCK) && (win_q <= LOAD_WINDOW) && !ee_busy;
   wire store_expire = armed_q && (win_q == STORE_WINDOW);
   wire load_expire = armed_q && (cmd_q == PAT_LOCK) && (win_q == LOAD_WINDOW);

   wire done = busy && (cnt_q == CNT_W'(1));
   wire [6:0] z_page = zptr_q[Z_PAGE_LSB +: PAGE_W];
   wire [4:0] z_word = zptr_q[Z_WORD_LSB +: WIDX_W];

   // Lock and fuse byte selection
   wire [7:0] lock_byte = {LOCK_PAD, lock_q[5:2], lock_q[1:0]};
   wire [7:0] special_byte = (zptr_q == Z_LOCK) ? lock_byte :
                             (zptr_q == Z_FUSE_LOW) ? FUSE_LOW :
                             (zptr_q == Z_FUSE_HIGH) ? FUSE_HIGH :
                             (zptr_q == Z_FUSE_EXT) ? {EXT_PAD, FUSE_EXT} :
                             PLAIN_LOAD;

   // Arming counter, counted from the cycle after the control write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_q <= 1'b0;
         cmd_q <= 5'h00;
         win_q <= 3'h0;
      end else if (arm_ok) begin
         armed_q <= 1'b1;
         cmd_q <= wr_pat;
         win_q <= 3'h1;
      end else if (store_go || special_go || store_expire || load_expire) begin
         armed_q <= 1'b0;
         win_q <= 3'h0;
      end else if (armed_q) begin
         win_q <= win_q + 3'h1;
      end
   end

   // Plain registers written by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ie_q <= 1'b0;
         zptr_q <= 16'h0000;
         data_q <= 16'h0000;
      end else begin
         if (ctrl_wr) begin
            ie_q <= pwdata[CTRL_IE];
         end
         if (apb_wr && hit_zptr) begin
            zptr_q <= pwdata[15:0];
         end
         if (apb_wr && hit_data) begin
            data_q <= pwdata[15:0];
         end
      end
   end

   // Load instruction result
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_q <= PLAIN_LOAD;
         special_q <= 1'b0;
      end else if (load_req) begin
         result_q <= special_go ? special_byte : PLAIN_LOAD;
         special_q <= special_go;
      end
   end

   // Lock bits: a zero in data bits 5..2 programs the bit, never unprograms it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_q <= LOCK_RESET;
      end else if (go_lock) begin
         lock_q[5:2] <= lock_q[5:2] & data_q[5:2];
      end
   end

   // Section busy flag; setting by a new write wins over clearing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rww_busy_q <= 1'b0;
      end else if (go_write && (z_page < RWW_PAGES)) begin
         rww_busy_q <= 1'b1;
      end else if (go_reen || go_load) begin
         rww_busy_q <= 1'b0;
      end
   end

   // Page-load in progress marker for the EEPROM discard
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loading_q <= 1'b0;
      end else if (go_load) begin
         loading_q <= 1'b1;
      end else if (buf_bus.clear || go_write) begin
         loading_q <= 1'b0;
      end
   end

   // Buffer controls
   wire reen_wr = arm_ok && (wr_pat == PAT_REEN);
   assign buf_bus.clear = done || reen_wr || (ee_start && loading_q);
   assign buf_bus.we = go_load;
   assign buf_bus.widx = z_word;
   assign buf_bus.wdata = data_q;
   assign buf_bus.ridx = flash_buf_idx;

   spfs_page_buf #(
      .WORDS(PAGE_WORDS)
   ) u_buf (
      .pclk(pclk),
      .presetn(presetn),
      .bus(buf_bus)
   );

   // Write engine survives a system reset and ends only on its own count
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         state_q <= SPFS_IDLE;
         cnt_q <= '0;
         page_q <= 7'h00;
         no_read_while_write_section_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         case (state_q)
            SPFS_IDLE: begin
               if (go_write) begin
                  state_q <= SPFS_PROG;
                  cnt_q <= CNT_W'(WRITE_CYCLES);
                  page_q <= z_page;
                  no_read_while_write_section_q <= (z_page >= RWW_PAGES);
                  start_q <= 1'b1;
               end
            end
            SPFS_PROG: begin
               if (done) begin
                  state_q <= SPFS_IDLE;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q - CNT_W'(1);
               end
            end
            default: begin
               state_q <= SPFS_IDLE;
            end
         endcase
      end
   end

   // Read mux
   wire [7:0] ctrl_rd = {ie_q, rww_busy_q, 1'b0, cmd_q & {5{armed_q}}} | {7'h00, selfprog_en};
   wire [3:0] status_rd = {special_q, loading_q, busy, ee_busy};
   always_comb begin
      prdata = 32'h00000000;
      if (hit_ctrl) begin
         prdata = {24'h000000, ctrl_rd};
      end else if (hit_zptr) begin
         prdata = {16'h0000, zptr_q};
      end else if (hit_data) begin
         prdata = {16'h0000, data_q};
      end else if (hit_result) begin
         prdata = {24'h000000, result_q};
      end else if (hit_status) begin
         prdata = {28'h0000000, status_rd};
      end
   end

   assign flash_wr_start = start_q;
   assign flash_wr_page = page_q;
   assign flash_buf_data = buf_bus.rdata;
   assign cpu_halt = busy && no_read_while_write_section_q;
   assign rww_read_block = rww_busy_q || (busy && !no_read_while_write_section_q);
   assign selfprog_irq = ie_q && !selfprog_en;

endmodule : spfs_top

/* bench/spfs_top_properties.sv */
/*
 Concurrent checks on the sequencer top ports.
 Assumes it is bound into spfs_top and handed the same WRITE_CYCLES.
*/
`timescale 1ns/1ps
module spfs_top_properties #(
   parameter int unsigned WRITE_CYCLES = 40
) (
   // Clock and resets
   input wire logic pclk,
   input wire logic presetn,
   input wire logic por_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Status, flash and CPU side
   input wire logic eeprom_write_busy,
   input wire logic flash_wr_start,
   input wire logic [6:0] flash_wr_page,
   input wire logic [4:0] flash_buf_idx,
   input wire logic [15:0] flash_buf_data,
   input wire logic cpu_halt,
   input wire logic rww_read_block,
   input wire logic selfprog_irq
);
   logic [31:0] halt_cnt_q;
   logic [31:0] halt_cnt_d;
   assign halt_cnt_d = cpu_halt ? halt_cnt_q + 32'h1 : 32'h0;
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) halt_cnt_q <= 32'h0;
      else halt_cnt_q <= halt_cnt_d;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_start_rww;
      flash_wr_start && flash_wr_page < 7'h60;
   endsequence
   sequence s_start_no_read_while_write_section;
      flash_wr_start && flash_wr_page >= 7'h60;
   endsequence
   a_rww_block: assert property (disable iff (!por_n) s_start_rww |=> rww_read_block && !cpu_halt)
      else $error("section write left reads open or halted the CPU");
   a_no_read_while_write_section_halt: assert property (disable iff (!por_n) s_start_no_read_while_write_section |=> cpu_halt [*4])
      else $error("own-section write did not halt the CPU");
   a_start_once: assert property (disable iff (!por_n) flash_wr_start |=> !flash_wr_start [*8])
      else $error("write start pulse repeated");
   a_page_hold: assert property (disable iff (!por_n) flash_wr_start |=> $stable(flash_wr_page) [*8])
      else $error("page number moved during write");
   a_irq_quiet: assert property (flash_wr_start |-> ##1 !selfprog_irq [*8])
      else $error("interrupt raised while enable bit set");
   a_halt_bound: assert property (disable iff (!por_n) halt_cnt_q <= WRITE_CYCLES + 1)
      else $error("CPU halt outlasted the write time");
   a_ee_refuse: assert property (eeprom_write_busy [*8] |-> !flash_wr_start)
      else $error("write started during EEPROM write");
   a_slverr_map: assert property (psel && penable && paddr > 12'h014 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
endmodule : spfs_top_properties

bind spfs_top spfs_top_properties #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
   .pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .eeprom_write_busy, .flash_wr_start, .flash_wr_page, .flash_buf_idx, .flash_buf_data, .cpu_halt,
   .rww_read_block, .selfprog_irq);

/* bench/spfs_flash_model.sv */
/*
 Flash macro model: on each start pulse it sweeps the buffer index and
 keeps the page image and page number it read.
 Assumes buffer data lags the index by one clock.
*/
`timescale 1ns/1ps
module spfs_flash_model (
   // Clock
   input wire logic pclk,
   // Sequencer side
   input wire logic flash_wr_start,
   input wire logic [6:0] flash_wr_page,
   output logic [4:0] flash_buf_idx,
   input wire logic [15:0] flash_buf_data
);
   logic [15:0] mem [32];
   logic [6:0] page;
   int writes;
   initial begin
      flash_buf_idx = 5'h00;
      writes = 0;
      forever begin
         @(posedge pclk);
         if (flash_wr_start === 1'b1) begin
            page = flash_wr_page;
            for (int i = 0; i < 33; i++) begin
               if (i < 32) flash_buf_idx <= 5'(i);
               @(posedge pclk);
               if (i > 0) mem[i - 1] = flash_buf_data;
            end
            writes++;
         end
      end
   end
endmodule : spfs_flash_model

/* bench/tb_top.sv */
/*
 Self-checking bench for the sequencer: APB master tasks, flash model and
 one task a scenario. Assumes the checker binds itself from its own file.
*/
`timescale 1ns/1ps
module tb_top
   import spfs_pkg::*;
;
   localparam int unsigned WC = 40;
   localparam logic [7:0] F_LO = 8'h5A;
   localparam logic [7:0] F_HI = 8'hC3;
   localparam logic [3:0] F_EX = 4'h6;
   localparam logic [7:0] C_LOCK = {3'h0, PAT_LOCK};
   localparam logic [7:0] C_LOAD = {3'h0, PAT_LOAD};
   localparam logic [7:0] C_WRITE = {3'h0, PAT_WRITE};
   localparam logic [7:0] C_REEN = {3'h0, PAT_REEN};
   logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic eeprom_write_busy, flash_wr_start, cpu_halt, rww_read_block, selfprog_irq;
   logic [6:0] flash_wr_page;
   logic [4:0] flash_buf_idx;
   logic [15:0] flash_buf_data;
   int fails, samples_checked, cycles;
   spfs_top #(.WRITE_CYCLES(WC), .FUSE_LOW(F_LO), .FUSE_HIGH(F_HI), .FUSE_EXT(F_EX)) DUT (
      .pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .eeprom_write_busy, .flash_wr_start, .flash_wr_page, .flash_buf_idx, .flash_buf_data, .cpu_halt,
      .rww_read_block, .selfprog_irq);
   spfs_flash_model FLASH (.pclk, .flash_wr_start, .flash_wr_page, .flash_buf_idx, .flash_buf_data);
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // One APB transfer; the request holds until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // The bench timeout ends this wait if pready never rises
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Gap 0 puts the instruction three edges after the control write
   task automatic cmd(input logic [7:0] pat, input int gap, input logic [1:0] op);
      apb(1'b1, ADDR_CTRL, {24'h0, pat});
      repeat (gap) @(posedge pclk);
      apb(1'b1, ADDR_INSTR, {30'h0, op});
   endtask : cmd
   task automatic t_reset_map();
      apb(1'b0, ADDR_CTRL, 32'h0);
      check("ctrl reset", rd, 32'h0);
      apb(1'b0, ADDR_RESULT, 32'h0);
      check("result reset", rd, 32'hFF);
      apb(1'b0, 12'h020, 32'h0);
      check("unmapped", {err, rd[30:0]}, 32'h80000000);
   endtask : t_reset_map
   task automatic t_bad();
      logic [7:0] pat [4];
      pat = '{8'h03, 8'h0D, 8'h83, 8'h1F};
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, ADDR_CTRL, {24'h0, pat[i]});
         apb(1'b0, ADDR_CTRL, 32'h0);
         check("ignored pattern", rd[7:0], pat[i] & 8'h80);
      end
   endtask : t_bad
   task automatic t_fuse(input logic [7:0] lock);
      logic [7:0] exp [4];
      exp = '{F_LO, lock, {4'hF, F_EX}, F_HI};
      for (int z = 0; z < 4; z++) begin
         apb(1'b1, ADDR_ZPTR, 32'(z));
         cmd(C_LOCK, 0, 2'h2);
         apb(1'b0, ADDR_RESULT, 32'h0);
         check("fuse or lock byte", rd, {24'h0, exp[z]});
         apb(1'b0, ADDR_CTRL, 32'h0);
         check("arm after read", rd[4:0], 5'h00);
      end
   endtask : t_fuse
   task automatic t_lock();
      apb(1'b1, ADDR_DATA, 32'hC7);
      cmd(C_LOCK, 0, 2'h1);
      apb(1'b1, ADDR_DATA, 32'h03);
      cmd(C_LOCK, 1, 2'h1);
      apb(1'b1, ADDR_ZPTR, 32'h1);
      cmd(C_LOCK, 1, 2'h2);
      apb(1'b0, ADDR_RESULT, 32'h0);
      check("late load", rd, 32'hFF);
      t_fuse(8'hC7);
   endtask : t_lock
   task automatic t_page();
      logic [4:0] idx [3];
      idx = '{5'h00, 5'h01, 5'h1F};
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, ADDR_ZPTR, 32'h1FC1 | {26'h0, idx[i], 1'b0});
         apb(1'b1, ADDR_DATA, 32'h1230 + i);
         cmd(C_LOAD, i % 2, 2'h1);
      end
      apb(1'b1, ADDR_ZPTR, 32'h4);
      cmd(C_LOAD, 2, 2'h1);
      apb(1'b1, ADDR_ZPTR, 32'h0140);
      cmd(8'h85, 0, 2'h1);
      repeat (2) @(posedge pclk);
      check("rww write", {cpu_halt, rww_read_block, selfprog_irq}, 3'b010);
      apb(1'b0, ADDR_CTRL, 32'h0);
      check("ctrl busy", {rd[7:6], rd[0]}, 3'b111);
      repeat (WC + 8) @(posedge pclk);
      check("after write", {selfprog_irq, rww_read_block, FLASH.page}, {2'b11, 7'h05});
      for (int i = 0; i < 3; i++) check("page word", FLASH.mem[idx[i]], 32'h1230 + i);
      check("late word", FLASH.mem[2], 32'hFFFF);
      apb(1'b0, ADDR_CTRL, 32'h0);
      check("enable cleared", rd[0], 1'b0);
      apb(1'b1, ADDR_ZPTR, 32'h1800);
      cmd(C_WRITE, 1, 2'h1);
      repeat (2) @(posedge pclk);
      check("own section halt", cpu_halt, 1'b1);
      repeat (WC + 8) @(posedge pclk);
      check("erased page", {FLASH.page, FLASH.mem[0]}, {7'h60, 16'hFFFF});
      cmd(C_REEN, 0, 2'h1);
      apb(1'b0, ADDR_CTRL, 32'h0);
      check("section free", {rd[6], rww_read_block}, 2'b00);
   endtask : t_page
   task automatic t_eeprom();
      // Word 4 is erased by the re-enable, word 3 only by the EEPROM discard
      apb(1'b1, ADDR_DATA, 32'h5555);
      apb(1'b1, ADDR_ZPTR, 32'h8);
      cmd(C_LOAD, 0, 2'h1);
      cmd(C_REEN, 0, 2'h1);
      apb(1'b1, ADDR_ZPTR, 32'h6);
      cmd(C_LOAD, 0, 2'h1);
      eeprom_write_busy <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b1, ADDR_ZPTR, 32'h0);
      cmd(C_WRITE, 0, 2'h1);
      apb(1'b0, ADDR_CTRL, 32'h0);
      check("refused arm", rd[0], 1'b0);
      cmd(C_LOCK, 0, 2'h2);
      apb(1'b0, ADDR_RESULT, 32'h0);
      check("refused fuse read", rd, 32'hFF);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check("status in eeprom write", rd, 32'h1);
      eeprom_write_busy <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b1, ADDR_ZPTR, 32'hA);
      cmd(C_LOAD, 0, 2'h1);
      apb(1'b1, ADDR_ZPTR, 32'h0040);
      cmd(C_WRITE, 0, 2'h1);
      repeat (WC + 8) @(posedge pclk);
      check("discarded words", {FLASH.mem[3], FLASH.mem[4]}, 32'hFFFFFFFF);
      check("kept word", FLASH.mem[5], 32'h5555);
   endtask : t_eeprom
   task automatic t_reset_write();
      apb(1'b1, ADDR_ZPTR, 32'h1800);
      cmd(C_WRITE, 0, 2'h1);
      repeat (3) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("write through reset", cpu_halt, 1'b1);
      repeat (WC + 8) @(posedge pclk);
      check("write finished", {cpu_halt, FLASH.writes[3:0]}, 5'h04);
   endtask : t_reset_write
   initial begin
      presetn = 1'b0;
      por_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      eeprom_write_busy = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      por_n <= 1'b1;
      t_reset_map();
      t_bad();
      t_fuse(8'hFF);
      t_lock();
      t_page();
      t_eeprom();
      t_reset_write();
      tally_and_finish();
   end
endmodule : tb_top
